//--- design/comparator_interface.sv
// Chosen here: the address map and the APB slave port.
`timescale 1ns/100ps

// Summary of operation
// [R1] Each comparator output is high when positive input exceeds negative.
// [R2] A comparator output reads 0 while its ready status is low.
// [R3] Normal mode runs both comparators independently.
// [R4] Two output events, each chosen by its own event source field.
// [R5] Each comparator has one interrupt: rise, fall or toggle.
// [R6] Window mode joins A negative and B positive to one common input.
// [R7] Window output high when common lies between B negative and A positive.
// [R8] Window output held at 0 while window ready is low.
// [R9] In window mode events may also follow the window output.
// [R10] Window mode adds a window interrupt: enter, leave or toggle.
// [R11] Common select overrides A negative and B positive selects.
// [R12] Speed bit one gives high speed, zero gives low power.
// [R13] Hysteresis field passes straight to its comparator.
// [R14] After enable, ready stays low for the start-up delay, then sets.
// [R15] Window ready only while both comparators are ready.
// [R16] After start-up, comparison toggles on or off with no new wait.
// [R17] Freeze in debug unless run-in-debug and mask bit are both set.
// [R18] Stays clocked while enabled and can request a wake from sleep.
// [R19] Comparator interrupt codes: 00 rise, 01 fall, 10 toggle.
// [R20] Event codes 0-2 A, 3-5 B, 6-8 window, 9-15 no event.
// [R21] Window interrupt codes: 00 enter, 01 leave, 10 toggle.
// [R22] Start-up counted in bus clocks; raised interrupts latch until cleared.
// [R23] Edges found against previous cycle; each event is a one-cycle pulse.
module comparator_interface (
  input  wire logic                      mclk,
  input  wire logic                      reset,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic [1:0]                comp_raw,
  input  wire logic                      debug_halt,
  input  wire logic                      run_in_debug,
  input  wire logic                      peripheral_debug_mask,
  output acmp_pkg::comp_drive_t          drive_a,
  output acmp_pkg::comp_drive_t          drive_b,
  output logic      [1:0]                cmp_out,
  output logic                           win_out,
  output logic      [1:0]                event_out,
  output logic      [2:0]                irq,
  output logic                           wake_req
);

  // ----------------------------------------------------------------
  // Configuration storage
  // ----------------------------------------------------------------
  acmp_pkg::comp_conf_t                  conf [2];
  logic [acmp_pkg::SEL_W-1:0]            window_common_input_field;
  logic [1:0]                            window_irq_condition_field;
  logic [3:0]                            event_source_field [2];
  logic [acmp_pkg::SUT_W-1:0]            startup_delay_field;
  logic                                  window_mode;
  logic [1:0]                            ac_en;
  logic [1:0]                            comparison_enable_bit;
  logic [1:0]                            comparator_ready_flag;
  logic [acmp_pkg::SUT_W-1:0]            sut_cnt [2];
  logic [1:0]                            sync1;
  logic [1:0]                            sync2;
  logic [1:0]                            out_prev;
  logic                                  win_prev;
  logic [2:0]                            flag;

  logic        access;
  logic        wr_take;
  logic        frozen;
  logic        window_ready_flag;
  logic [1:0]  next_out;
  logic        next_win;
  logic [2:0]  irq_hit;
  logic [1:0]  ev_hit;
  logic [31:0] rd_val;
  logic        rd_ok;

  // Condition test shared by comparator and window interrupts.
  function automatic logic cond_hit(input logic [1:0] c,
                                    input logic prev,
                                    input logic cur);
    case (c)
      acmp_pkg::COND_RISE:   cond_hit = cur & ~prev;
      acmp_pkg::COND_FALL:   cond_hit = prev & ~cur;
      acmp_pkg::COND_TOGGLE: cond_hit = prev ^ cur;
      default:               cond_hit = 1'b0;
    endcase
  endfunction

  // Event decode: groups of three codes per source, rise/fall/either.
  function automatic logic ev_decode(input logic [3:0] code,
                                     input logic [2:0] prev,
                                     input logic [2:0] cur,
                                     input logic       wmode);
    logic [1:0] src;
    logic [1:0] kind;
    src  = 2'd0;
    kind = 2'd0;
    if (code > acmp_pkg::EVENT_SOURCE_FIELD_LAST) begin
      ev_decode = 1'b0; // see [R20]
    end else begin
      src  = 2'(code / 4'd3);
      kind = 2'(code % 4'd3);
      if (src == 2'd2 && !wmode) begin
        ev_decode = 1'b0; // see [R9]
      end else begin
        ev_decode = cond_hit(kind, prev[src], cur[src]); // see [R4]
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // APB slave: one wait state, read data captured with pready
  // ----------------------------------------------------------------
  assign access  = psel & penable;
  assign wr_take = access & pready & pwrite;

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok  = 1'b1;
    case (paddr)
      acmp_pkg::OFF_CONFA:   rd_val = {conf[0].pad_off, 2'b00,
                                       conf[0].high_speed, 2'b00,
                                       conf[0].hyst, 4'h0, conf[0].neg_sel,
                                       4'h0, conf[0].pos_sel, 6'h00,
                                       conf[0].irq_cond};
      acmp_pkg::OFF_CONFB:   rd_val = {conf[1].pad_off, 2'b00,
                                       conf[1].high_speed, 2'b00,
                                       conf[1].hyst, 4'h0, conf[1].neg_sel,
                                       4'h0, conf[1].pos_sel, 6'h00,
                                       conf[1].irq_cond};
      acmp_pkg::OFF_WCONF:   rd_val = {20'h0_0000, window_common_input_field,
                                       6'h00, window_irq_condition_field};
      acmp_pkg::OFF_EVSRC0:  rd_val = {28'h000_0000, event_source_field[0]};
      acmp_pkg::OFF_EVSRC1:  rd_val = {28'h000_0000, event_source_field[1]};
      acmp_pkg::OFF_EN,
      acmp_pkg::OFF_DIS,
      acmp_pkg::OFF_SCR:     rd_val = 32'h0000_0000;
      acmp_pkg::OFF_SUT:     rd_val = {16'h0000, startup_delay_field};
      acmp_pkg::OFF_SR:      rd_val = {21'h00_0000, flag, 
                                       comparison_enable_bit, window_ready_flag,
                                       comparator_ready_flag, win_out,
                                       cmp_out};
      acmp_pkg::OFF_VERSION: rd_val = acmp_pkg::VERSION_VALUE;
      default:               rd_ok  = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= access & ~pready;
      prdata  <= (access & ~pready & ~pwrite) ? rd_val : 32'h0000_0000;
      pslverr <= access & ~pready & ~rd_ok;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < 2; i++) begin
        conf[i]               <= acmp_pkg::comp_conf_t'(0);
        conf[i].pad_off       <= acmp_pkg::CONF_RESET[acmp_pkg::CONF_PAD_OFF];
        event_source_field[i] <= 4'h0;
      end
      window_common_input_field  <= '0;
      window_irq_condition_field <= 2'h0;
      startup_delay_field        <= '0;
    end else if (wr_take) begin
      for (int i = 0; i < 2; i++) begin
        if (paddr == (i == 0 ? acmp_pkg::OFF_CONFA : acmp_pkg::OFF_CONFB))
        begin
          conf[i].pad_off    <= pwdata[acmp_pkg::CONF_PAD_OFF];
          conf[i].high_speed <= pwdata[acmp_pkg::CONF_SPEED];
          conf[i].hyst       <= pwdata[acmp_pkg::CONF_HYST_LO +: 2];
          conf[i].neg_sel    <= pwdata[acmp_pkg::CONF_NEG_LO +:
                                       acmp_pkg::SEL_W];
          conf[i].pos_sel    <= pwdata[acmp_pkg::CONF_POS_LO +:
                                       acmp_pkg::SEL_W];
          conf[i].irq_cond   <= pwdata[acmp_pkg::CONF_IRQ_LO +: 2];
        end
      end
      if (paddr == acmp_pkg::OFF_WCONF) begin
        window_common_input_field  <= pwdata[acmp_pkg::WCONF_SEL_LO +:
                                             acmp_pkg::SEL_W];
        window_irq_condition_field <= pwdata[acmp_pkg::WCONF_IRQ_LO +: 2];
      end
      if (paddr == acmp_pkg::OFF_EVSRC0)
        event_source_field[0] <= pwdata[3:0];
      if (paddr == acmp_pkg::OFF_EVSRC1)
        event_source_field[1] <= pwdata[3:0];
      if (paddr == acmp_pkg::OFF_SUT)
        startup_delay_field <= pwdata[acmp_pkg::SUT_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Enable, start-up and comparison control
  // ----------------------------------------------------------------
  // Debug freeze stalls the start-up count and all edge detection.
  assign frozen = debug_halt
                  & ~(run_in_debug & peripheral_debug_mask); // see [R17]

  always_ff @(posedge mclk) begin
    if (reset) begin
      ac_en                 <= 2'b00;
      comparison_enable_bit <= 2'b00;
      comparator_ready_flag <= 2'b00;
      window_mode           <= 1'b0;
      for (int i = 0; i < 2; i++)
        sut_cnt[i] <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wr_take && paddr == acmp_pkg::OFF_DIS &&
            pwdata[acmp_pkg::EN_AC_LO + i]) begin
          ac_en[i]                 <= 1'b0;
          comparator_ready_flag[i] <= 1'b0;
          comparison_enable_bit[i] <= 1'b0;
        end else if (wr_take && paddr == acmp_pkg::OFF_EN &&
                     pwdata[acmp_pkg::EN_AC_LO + i] && !ac_en[i]) begin
          // A fresh enable restarts the wait from zero.
          ac_en[i]                 <= 1'b1;
          comparison_enable_bit[i] <= 1'b1;
          sut_cnt[i]               <= '0; // see [R22]
        end else begin
          if (ac_en[i] && !comparator_ready_flag[i] && !frozen) begin
            if (sut_cnt[i] >= startup_delay_field)
              comparator_ready_flag[i] <= 1'b1; // see [R14]
            else
              sut_cnt[i] <= sut_cnt[i] + 16'h0001;
          end
          // Comparison switching leaves ready untouched.
          if (wr_take && paddr == acmp_pkg::OFF_EN &&
              pwdata[acmp_pkg::EN_CMP_LO + i])
            comparison_enable_bit[i] <= 1'b1; // see [R16]
          if (wr_take && paddr == acmp_pkg::OFF_DIS &&
              pwdata[acmp_pkg::EN_CMP_LO + i])
            comparison_enable_bit[i] <= 1'b0; // see [R16]
        end
      end
      if (wr_take && paddr == acmp_pkg::OFF_EN &&
          pwdata[acmp_pkg::EN_WINDOW])
        window_mode <= 1'b1;
      if (wr_take && paddr == acmp_pkg::OFF_DIS &&
          pwdata[acmp_pkg::EN_WINDOW])
        window_mode <= 1'b0;
    end
  end

  assign window_ready_flag = window_mode
                             & (&comparator_ready_flag); // see [R15]

  // ----------------------------------------------------------------
  // Analog drive
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      drive_a <= '{default: '0, pad_off: 1'b1};
      drive_b <= '{default: '0, pad_off: 1'b1};
    end else begin
      drive_a.enable     <= ac_en[0];
      drive_a.high_speed <= conf[0].high_speed; // see [R12]
      drive_a.hyst       <= conf[0].hyst; // see [R13]
      drive_a.pos_sel    <= conf[0].pos_sel;
      drive_a.neg_sel    <= window_mode ? window_common_input_field
                                        : conf[0].neg_sel; // see [R6] [R11]
      drive_a.pad_off    <= conf[0].pad_off;
      drive_b.enable     <= ac_en[1];
      drive_b.high_speed <= conf[1].high_speed; // see [R12]
      drive_b.hyst       <= conf[1].hyst; // see [R13]
      drive_b.pos_sel    <= window_mode ? window_common_input_field
                                        : conf[1].pos_sel; // see [R6] [R11]
      drive_b.neg_sel    <= conf[1].neg_sel;
      drive_b.pad_off    <= conf[1].pad_off;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, window function, events and interrupt flags
  // ----------------------------------------------------------------
  // The raw compare lines are asynchronous to mclk, hence two flops.
  always_ff @(posedge mclk) begin
    if (reset) begin
      sync1 <= 2'b00;
      sync2 <= 2'b00;
    end else begin
      sync1 <= comp_raw;
      sync2 <= sync1;
    end
  end

  // Each comparator is gated only by its own ready and comparison bits.
  assign next_out = sync2 & comparator_ready_flag
                    & comparison_enable_bit; // see [R1] [R2] [R3]
  // A high means common below A's positive; B high means above B's negative.
  assign next_win = window_ready_flag & next_out[0]
                    & next_out[1]; // see [R7] [R8]

  always_comb begin
    for (int i = 0; i < 2; i++)
      irq_hit[i] = ~frozen & cond_hit(conf[i].irq_cond, out_prev[i],
                                      cmp_out[i]); // see [R5] [R19]
    irq_hit[2] = ~frozen & window_mode
                 & cond_hit(window_irq_condition_field, win_prev,
                            win_out); // see [R10] [R21]
    for (int i = 0; i < 2; i++)
      ev_hit[i] = ~frozen & ev_decode(event_source_field[i],
                                      {win_prev, out_prev},
                                      {win_out, cmp_out}, window_mode);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      cmp_out   <= 2'b00;
      win_out   <= 1'b0;
      out_prev  <= 2'b00;
      win_prev  <= 1'b0;
      event_out <= 2'b00;
    end else begin
      cmp_out  <= next_out;
      win_out  <= next_win;
      if (!frozen) begin
        out_prev <= cmp_out; // see [R23]
        win_prev <= win_out;
      end
      event_out <= ev_hit; // see [R23]
    end
  end

  // Set wins over a clear arriving in the same cycle.
  always_ff @(posedge mclk) begin
    if (reset) begin
      flag     <= 3'b000;
      irq      <= 3'b000;
      wake_req <= 1'b0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (irq_hit[i])
          flag[i] <= 1'b1; // see [R22]
        else if (wr_take && paddr == acmp_pkg::OFF_SCR &&
                 pwdata[acmp_pkg::SR_FLAG_LO + i])
          flag[i] <= 1'b0;
      end
      irq      <= flag;
      wake_req <= |flag; // see [R18]
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_ready_gates_out: assert property ( // see [R2]
    !comparator_ready_flag[0] |=> !cmp_out[0])
    else $error("comparator A output high while not ready");

  a_window_ready_gate: assert property ( // see [R8] [R15]
    !(comparator_ready_flag[0] && comparator_ready_flag[1]) |=> !win_out)
    else $error("window output high while not ready");

  a_window_inside: assert property ( // see [R7]
    win_out |-> cmp_out[0] && cmp_out[1] && $past(window_mode))
    else $error("window output high outside the window");

  a_startup_wait: assert property ( // see [R14]
    $rose(comparator_ready_flag[0]) |->
      $past(sut_cnt[0]) >= $past(startup_delay_field))
    else $error("ready set before start-up delay ran out");

  a_event_a_rise: assert property ( // see [R4] [R23]
    (event_source_field[0] == 4'h0 && !frozen && cmp_out[0]
     && !out_prev[0]) |=> event_out[0])
    else $error("rising event on comparator A missed");

  a_event_code_dead: assert property ( // see [R20]
    (event_source_field[1] > acmp_pkg::EVENT_SOURCE_FIELD_LAST) |=> !event_out[1])
    else $error("event raised for an unused source code");

  a_irq_flag_latch: assert property ( // see [R5] [R22]
    irq_hit[1] |=> flag[1] ##1 irq[1])
    else $error("comparator B interrupt not latched");

  a_common_override: assert property ( // see [R11]
    window_mode |=> drive_b.pos_sel == $past(window_common_input_field))
    else $error("common input not applied in window mode");

  a_debug_freeze: assert property ( // see [R17]
    frozen |=> event_out == 2'b00)
    else $error("event raised while frozen");

  c_ready_rise: cover property ($rose(comparator_ready_flag[1]));
  c_window_enter: cover property ($rose(win_out));
  c_event_pulse: cover property (event_out[0] ##1 !event_out[0]);
  c_flag_cleared: cover property (flag[0] ##1 !flag[0]);

endmodule

//--- pkg/acmp_pkg.sv
package acmp_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the APB)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CONFA   = 8'h00;
  localparam logic [7:0] OFF_CONFB   = 8'h04;
  localparam logic [7:0] OFF_WCONF   = 8'h08;
  localparam logic [7:0] OFF_EVSRC0  = 8'h0C;
  localparam logic [7:0] OFF_EVSRC1  = 8'h10;
  localparam logic [7:0] OFF_EN      = 8'h1C;
  localparam logic [7:0] OFF_DIS     = 8'h20;
  localparam logic [7:0] OFF_SUT     = 8'h24;
  localparam logic [7:0] OFF_SR      = 8'h40;
  localparam logic [7:0] OFF_SCR     = 8'h44;
  localparam logic [7:0] OFF_VERSION = 8'h48;

  // Identification value; arbitrary.
  localparam logic [31:0] VERSION_VALUE = 32'h0000_0001;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CONF_PAD_OFF = 31;
  localparam int CONF_SPEED   = 28;
  localparam int CONF_HYST_LO = 24;
  localparam int CONF_NEG_LO  = 16;
  localparam int CONF_POS_LO  = 8;
  localparam int CONF_IRQ_LO  = 0;
  localparam int WCONF_SEL_LO = 8;
  localparam int WCONF_IRQ_LO = 0;
  // EN / DIS bits.
  localparam int EN_AC_LO     = 0;
  localparam int EN_CMP_LO    = 2;
  localparam int EN_WINDOW    = 4;
  // SR bits; SCR clears the flag bits.
  localparam int SR_OUT_LO    = 0;
  localparam int SR_WOUT      = 2;
  localparam int SR_RDY_LO    = 3;
  localparam int SR_WRDY      = 5;
  localparam int SR_ENA_LO    = 6;
  localparam int SR_FLAG_LO   = 8;

  localparam int SEL_W  = 4;
  localparam int SUT_W  = 16;
  localparam logic [31:0] CONF_RESET = 32'h8000_0000;

  // Interrupt condition codes.
  localparam logic [1:0] COND_RISE   = 2'h0;
  localparam logic [1:0] COND_FALL   = 2'h1;
  localparam logic [1:0] COND_TOGGLE = 2'h2;
  // Highest event source code that selects anything.
  localparam logic [3:0] EVENT_SOURCE_FIELD_LAST  = 4'h8;

  typedef struct packed {
    logic             pad_off;
    logic             high_speed;
    logic [1:0]       hyst;
    logic [SEL_W-1:0] neg_sel;
    logic [SEL_W-1:0] pos_sel;
    logic [1:0]       irq_cond;
  } comp_conf_t;

  typedef struct packed {
    logic             enable;
    logic             high_speed;
    logic [1:0]       hyst;
    logic [SEL_W-1:0] pos_sel;
    logic [SEL_W-1:0] neg_sel;
    logic             pad_off;
  } comp_drive_t;

endpackage

//--- verification/comparator_pair_model.sv
`timescale 1ns/100ps
module comparator_pair_model (
  input  wire logic                  mclk,
  input  wire acmp_pkg::comp_drive_t drive_a,
  input  wire acmp_pkg::comp_drive_t drive_b,
  input  wire logic [15:0][7:0]      volt,
  output logic      [1:0]            comp_raw
);
  // A core that is switched off gives no usable level, so it toggles.
  logic idle = 1'b0;
  always @(posedge mclk) begin
    idle <= ~idle;
  end
  always_comb begin
    comp_raw[0] = idle;
    comp_raw[1] = idle;
    if (drive_a.enable) begin
      comp_raw[0] = volt[drive_a.pos_sel]
                    > volt[drive_a.neg_sel];
    end
    if (drive_b.enable) begin
      comp_raw[1] = volt[drive_b.pos_sel]
                    > volt[drive_b.neg_sel];
    end
  end
endmodule

//--- verification/comparator_interface_test.sv
`timescale 1ns/100ps
module comparator_interface_test;
  logic                  mclk = 1'b0;
  logic                  reset = 1'b1;
  logic                  psel = 1'b0;
  logic                  penable = 1'b0;
  logic                  pwrite = 1'b0;
  logic [7:0]            paddr = 8'h00;
  logic [31:0]           pwdata = 32'h0000_0000;
  logic [31:0]           prdata;
  logic [31:0]           rd;
  logic                  pready;
  logic                  pslverr;
  logic                  err;
  logic                  debug_halt = 1'b0;
  logic                  run_in_debug = 1'b0;
  logic                  peripheral_debug_mask = 1'b0;
  logic [1:0]            comp_raw;
  logic [1:0]            cmp_out;
  logic [1:0]            event_out;
  logic                  win_out;
  logic                  wake_req;
  logic [2:0]            irq;
  logic [15:0][7:0]      volt = '0;
  acmp_pkg::comp_drive_t drive_a;
  acmp_pkg::comp_drive_t drive_b;
  int                    n_errors = 0;
  int                    total_checks = 0;
  int                    cyc = 0;
  int                    ev0 = 0;
  int                    ev1 = 0;
  int                    e0;
  int                    e1;

  always #20 mclk = ~mclk;

  comparator_interface dut_u (.mclk, .reset, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .comp_raw, .debug_halt,
    .run_in_debug, .peripheral_debug_mask, .drive_a, .drive_b, .cmp_out,
    .win_out, .event_out, .irq, .wake_req);
  comparator_pair_model model_u (.mclk, .drive_a, .drive_b, .volt,
    .comp_raw);

  task automatic end_sim;
    if (n_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Counting pulse cycles also catches a pulse that stands too long.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (event_out[0] === 1'b1) ev0 <= ev0 + 1;
    if (event_out[1] === 1'b1) ev1 <= ev1 + 1;
    if (cyc == 20000) begin
      n_errors++;
      end_sim;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) n_errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic setv(input int i, input logic [7:0] v);
    @(posedge mclk);
    volt[i] <= v;
    tick(8);
  endtask

  function automatic int evexp(input int c);
    case (c)
      0, 1, 6, 7: return 1;
      2, 8: return 2;
      default: return 0;
    endcase
  endfunction

  initial begin
    volt[0] = 8'd200;
    volt[1] = 8'd100;
    volt[2] = 8'd100;
    volt[3] = 8'd50;
    tick(16);
    reset <= 1'b0;
    apb(1'b0, acmp_pkg::OFF_CONFA, 0);
    chk(rd, acmp_pkg::CONF_RESET);
    apb(1'b0, acmp_pkg::OFF_VERSION, 0);
    chk(rd, acmp_pkg::VERSION_VALUE);
    apb(1'b0, 8'h14, 0);
    chk(err, 1'b1);
    wr(acmp_pkg::OFF_CONFA, 32'h1201_0000);
    wr(acmp_pkg::OFF_CONFB, 32'h0103_0200);
    tick(2);
    chk({drive_a.high_speed, drive_a.hyst, drive_b.high_speed,
         drive_b.hyst}, 6'b110_001);
    wr(acmp_pkg::OFF_SUT, 32'd20);
    wr(acmp_pkg::OFF_EN, 32'h0000_0001);
    tick(6);
    chk(cmp_out[0], 1'b0);
    apb(1'b0, acmp_pkg::OFF_SR, 0);
    chk(rd[4:3], 2'b00);
    tick(20);
    chk(cmp_out, 2'b01);
    apb(1'b0, acmp_pkg::OFF_SR, 0);
    chk(rd[4:3], 2'b01);
    for (int c = 0; c < 3; c++) begin
      wr(acmp_pkg::OFF_CONFA, 32'h1201_0000 | c);
      wr(acmp_pkg::OFF_SCR, 32'h0000_0700);
      setv(1, 8'd250);
      chk(irq[0], c != 0);
      wr(acmp_pkg::OFF_SCR, 32'h0000_0700);
      setv(1, 8'd100);
      chk({irq[0], wake_req}, {2{c != 1}});
    end
    wr(acmp_pkg::OFF_SUT, 32'd1000);
    wr(acmp_pkg::OFF_DIS, 32'h0000_0004);
    tick(6);
    chk(cmp_out[0], 1'b0);
    wr(acmp_pkg::OFF_EN, 32'h0000_0004);
    tick(6);
    chk(cmp_out[0], 1'b1);
    wr(acmp_pkg::OFF_SUT, 32'd20);
    wr(acmp_pkg::OFF_WCONF, 32'h0000_0200);
    wr(acmp_pkg::OFF_EN, 32'h0000_0012);
    tick(3);
    chk(win_out, 1'b0);
    apb(1'b0, acmp_pkg::OFF_SR, 0);
    chk(rd[5], 1'b0);
    tick(30);
    apb(1'b0, acmp_pkg::OFF_SR, 0);
    chk({rd[5:3], win_out}, 4'b1111);
    chk({drive_a.neg_sel, drive_b.pos_sel, drive_a.pos_sel,
         drive_b.neg_sel}, 16'h2203);
    for (int c = 0; c < 3; c++) begin
      wr(acmp_pkg::OFF_WCONF, 32'h0000_0200 | c);
      wr(acmp_pkg::OFF_SCR, 32'h0000_0700);
      setv(2, 8'd250);
      chk({win_out, irq[2]}, {1'b0, c != 0});
      wr(acmp_pkg::OFF_SCR, 32'h0000_0700);
      setv(2, 8'd100);
      chk(irq[2], c != 1);
    end
    for (int c = 0; c < 16; c++) begin
      wr(acmp_pkg::OFF_EVSRC0, c);
      wr(acmp_pkg::OFF_EVSRC1, 32'd8);
      e0 = ev0;
      e1 = ev1;
      setv(2, 8'd250);
      setv(2, 8'd100);
      chk(ev0 - e0, evexp(c));
      chk(ev1 - e1, 2);
    end
    debug_halt <= 1'b1;
    e1 = ev1;
    setv(2, 8'd250);
    setv(2, 8'd100);
    chk(ev1 - e1, 0);
    run_in_debug <= 1'b1;
    peripheral_debug_mask <= 1'b1;
    e1 = ev1;
    setv(2, 8'd250);
    setv(2, 8'd100);
    chk(ev1 - e1, 2);
    end_sim;
  end
endmodule
